// File: core/cid_pkg.sv
package cid_pkg;

  // field positions within the instruction word
  localparam int OPC_LSB   = 26;
  localparam int SRC_LSB   = 21;
  localparam int TGT_LSB   = 16;
  localparam int DST_LSB   = 11;
  localparam int SHAMT_LSB = 6;
  localparam int FUNC_LSB  = 0;
  localparam int IMM_LSB   = 0;
  localparam int JIDX_LSB  = 0;
  localparam int OPC_W     = 6;
  localparam int REG_W     = 5;
  localparam int FUNC_W    = 6;
  localparam int IMM_W     = 16;
  localparam int JIDX_W    = 26;
  localparam int JLOW_W    = 28;
  localparam int WORD_W    = 32;

  // primary opcode values
  localparam logic [5:0] OPC_SPECIAL  = 6'h00;
  localparam logic [5:0] OPC_REG_IMM_CLASS = 6'h01;
  localparam logic [5:0] OPC_XOR_WITH_CONSTANT = 6'h0E;
  localparam logic [5:0] OPC_SYSCTL   = 6'h10;
  localparam logic [5:0] OPC_FLOAT    = 6'h11;
  localparam logic [5:0] OPC_SECOND_COPROC = 6'h12;
  localparam logic [5:0] OPC_THIRD_COPROC  = 6'h13;

  // encodings valid in the second-level table
  localparam logic [63:0] L2_OPC_MASK   = 64'hEFEF_4F7F_00FF_FFFF;
  localparam logic [63:0] L2_FUNC_MASK  = 64'h004E_0CFF_0F0F_B3DD;
  localparam logic [31:0] L2_RIMM_MASK  = 32'h0003_4C03;
  // third coprocessor class and its loads and stores
  localparam logic [63:0] THIRD_COPROC_MASK = 64'h8888_0000_0008_0000;
  // coprocessor loads and stores, units 1 to 3
  localparam logic [63:0] CPLS_OPC_MASK = 64'hEEEE_0000_0000_0000;

  // architecture mode of the decoder
  typedef enum logic [2:0] {
    CID_MODE_L2 = 3'b001,
    CID_MODE_L3 = 3'b010,
    CID_MODE_L4 = 3'b100
  } cid_mode_e;

  // fields split out of one word
  typedef struct packed {
    logic [5:0]  opcode;
    logic [4:0]  source_specifier;
    logic [4:0]  target_specifier;
    logic [4:0]  dest_specifier;
    logic [4:0]  shift_amount;
    logic [5:0]  func;
    logic [15:0] imm;
    logic [27:0] jump_low;
  } cid_fields_s;

  // class and dispatch controls
  typedef struct packed {
    logic       special;
    logic       register_immediate_class;
    logic [3:0] cop_dispatch;
    logic       float_load_store;
    logic       float_indexed_class;
    logic       cond_move_float_flag;
    logic       reserved_exc;
    logic       align_exc;
  } cid_ctrl_s;

endpackage

// File: core/cid_decode.sv
`timescale 1ns/1ps
module cid_decode
  import cid_pkg::*;
#(
  parameter int          XLEN        = 64,       // general register width
  parameter logic        CP2_PRESENT = 1'b1,     // second coprocessor fitted
  parameter logic [5:0]  CMOV_FUNC   = 6'h01,    // float-flag move function
  parameter logic [63:0] L3_OPC_ADD  = 64'h0,    // opcodes new at level 3
  parameter logic [63:0] L4_OPC_ADD  = 64'h0,    // opcodes new at level 4
  parameter logic [63:0] L3_FUNC_ADD = 64'h0,    // functions new at level 3
  parameter logic [63:0] L4_FUNC_ADD = 64'h0,    // functions new at level 4
  parameter logic [31:0] L3_RIMM_ADD = 32'h0     // target codes new at 3
)(
  input  wire logic              core_clk,        // core clock
  input  wire logic              resetn,          // async reset, low
  input  wire logic              in_valid,        // word presented
  input  wire logic [31:0]       in_word,         // instruction word
  input  wire logic [1:0]        in_addr_low,     // fetch address bits 1..0
  input  wire cid_pkg::cid_mode_e mode,           // architecture mode
  input  wire logic [XLEN-1:0]   source_value,    // source register value
  output cid_pkg::cid_fields_s   fields_ff,       // split fields
  output cid_pkg::cid_ctrl_s     ctrl_ff,         // class and dispatch
  output logic                   out_valid_ff,    // decode result valid
  output logic                   wr_en_ff,        // xor result write
  output logic [4:0]             wr_idx_ff,       // general_register index
  output logic [XLEN-1:0]        wr_data_ff       // xor result
);
  import cid_pkg::*;

  cid_fields_s     nxt_fields;   // fields of the incoming word
  cid_ctrl_s       nxt_ctrl;     // controls of the incoming word
  logic            is_xor_const; // xor-with-constant recognised
  logic [XLEN-1:0] nxt_xor;      // xor result

  // opcode legal at the selected level; the third coprocessor slot is
  // never legal as such, because this core is fourth level
  function automatic logic opc_ok(input logic [5:0] opc,
                                  input cid_mode_e  m);
    logic [63:0] msk;
    msk = L2_OPC_MASK & ~THIRD_COPROC_MASK;
    if (m != CID_MODE_L2)
      msk = msk | L3_OPC_ADD;
    if (m == CID_MODE_L4)
      msk = msk | L4_OPC_ADD | (64'h1 << OPC_THIRD_COPROC);
    if (!CP2_PRESENT)
    begin
      // class slot plus its four load and store slots
      msk[OPC_SECOND_COPROC] = 1'b0;
      msk[OPC_SECOND_COPROC + 6'h20] = 1'b0;
      msk[OPC_SECOND_COPROC + 6'h24] = 1'b0;
      msk[OPC_SECOND_COPROC + 6'h28] = 1'b0;
      msk[OPC_SECOND_COPROC + 6'h2C] = 1'b0;
    end
    return msk[opc];
  endfunction

  // function code legal at the selected level
  function automatic logic func_ok(input logic [5:0] fn,
                                   input cid_mode_e  m);
    logic [63:0] msk;
    msk = L2_FUNC_MASK;
    if (m != CID_MODE_L2)
      msk = msk | L3_FUNC_ADD;
    if (m == CID_MODE_L4)
      msk = msk | L4_FUNC_ADD | (64'h1 << CMOV_FUNC);
    return msk[fn];
  endfunction

  // target code legal under the register-immediate class
  function automatic logic rimm_ok(input logic [4:0] tc,
                                   input cid_mode_e  m);
    logic [31:0] msk;
    msk = L2_RIMM_MASK;
    if (m != CID_MODE_L2)
      msk = msk | L3_RIMM_ADD;
    return msk[tc];
  endfunction

  // split the word at fixed positions
  always_comb
  begin
    nxt_fields.opcode           = in_word[OPC_LSB +: OPC_W];
    nxt_fields.source_specifier = in_word[SRC_LSB +: REG_W];
    nxt_fields.target_specifier = in_word[TGT_LSB +: REG_W];
    nxt_fields.dest_specifier   = in_word[DST_LSB +: REG_W];
    nxt_fields.shift_amount     = in_word[SHAMT_LSB +: REG_W];
    nxt_fields.func             = in_word[FUNC_LSB +: FUNC_W];
    nxt_fields.imm              = in_word[IMM_LSB +: IMM_W];
    nxt_fields.jump_low = {in_word[JIDX_LSB +: JIDX_W], 2'b00};
  end

  // class decode, always steered by the primary opcode first
  always_comb
  begin
    nxt_ctrl = '0;
    // misaligned fetch cannot be a whole instruction word
    nxt_ctrl.align_exc = (in_addr_low != 2'b00);
    if (!opc_ok(nxt_fields.opcode, mode))
    begin
      // covers the third coprocessor in the restricted modes
      nxt_ctrl.reserved_exc = 1'b1;
    end
    else if (nxt_fields.opcode == OPC_SPECIAL)
    begin
      // function field only looked at inside this class
      nxt_ctrl.special = 1'b1;
      if (!func_ok(nxt_fields.func, mode))
        nxt_ctrl.reserved_exc = 1'b1;
      else if (mode == CID_MODE_L4 && nxt_fields.func == CMOV_FUNC)
      begin
        nxt_ctrl.cond_move_float_flag = 1'b1;
        nxt_ctrl.cop_dispatch[1] = 1'b1;
      end
    end
    else if (nxt_fields.opcode == OPC_REG_IMM_CLASS)
    begin
      // target field names the operation here, not a register
      nxt_ctrl.register_immediate_class = 1'b1;
      if (!rimm_ok(nxt_fields.target_specifier, mode))
        nxt_ctrl.reserved_exc = 1'b1;
    end
    else if (nxt_fields.opcode == OPC_THIRD_COPROC)
    begin
      // slot reused as the indexed float class at level 4
      nxt_ctrl.float_indexed_class = 1'b1;
      nxt_ctrl.cop_dispatch[1] = 1'b1;
    end
    else if (nxt_fields.opcode[5:2] == OPC_SYSCTL[5:2])
    begin
      // whole class handed over, system control unseen here
      nxt_ctrl.cop_dispatch[nxt_fields.opcode[1:0]] = 1'b1;
    end
    else if (CPLS_OPC_MASK[nxt_fields.opcode])
    begin
      // coprocessor number lives in the low opcode bits
      nxt_ctrl.cop_dispatch[nxt_fields.opcode[1:0]] = 1'b1;
      nxt_ctrl.float_load_store = (nxt_fields.opcode[1:0] == 2'd1);
    end
  end

  // system control class needs no decode beyond dispatch
  // bit 0 of cop_dispatch is the system control unit

  // xor-with-constant recognised by opcode alone, no own fault
  assign is_xor_const = (nxt_fields.opcode == OPC_XOR_WITH_CONSTANT);
  // immediate zero-extended; sign extension would corrupt high bits
  assign nxt_xor = source_value ^
                   {{(XLEN-IMM_W){1'b0}}, nxt_fields.imm};

  // decode outputs, one stage after the word
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      fields_ff    <= '0;
      ctrl_ff      <= '0;
      out_valid_ff <= 1'b0;
    end
    else
    begin
      fields_ff    <= nxt_fields;
      ctrl_ff      <= in_valid ? nxt_ctrl : '0;
      out_valid_ff <= in_valid;
    end
  end

  // xor result write port
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wr_en_ff   <= 1'b0;
      wr_idx_ff  <= '0;
      wr_data_ff <= '0;
    end
    else
    begin
      // a misaligned word is not an instruction, so no write
      wr_en_ff   <= in_valid && is_xor_const && !nxt_ctrl.align_exc;
      wr_idx_ff  <= nxt_fields.target_specifier;
      wr_data_ff <= nxt_xor;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  sequence s_xor_in;
    in_valid && is_xor_const && in_addr_low == 2'b00;
  endsequence

  sequence s_xor_out;
    wr_en_ff && wr_idx_ff == fields_ff.target_specifier;
  endsequence

  a_xor_result: assert property (s_xor_in |=> s_xor_out ##0
    wr_data_ff == ($past(source_value) ^ XLEN'(fields_ff.imm)))
    else $error("xor result or target wrong");
  a_xor_no_exc: assert property (wr_en_ff |->
    !ctrl_ff.reserved_exc && fields_ff.opcode == 6'h0E)
    else $error("xor-with-constant faulted");
  a_misalign_flag: assert property (in_valid && in_addr_low != 2'b00
    |=> ctrl_ff.align_exc && !wr_en_ff)
    else $error("misaligned word not flagged");
  a_field_split: assert property (in_valid |=>
    fields_ff.opcode == $past(in_word[31:26]) &&
    fields_ff.func == $past(in_word[5:0]) &&
    fields_ff.shift_amount == $past(in_word[10:6]))
    else $error("fields split wrongly");
  a_jump_low: assert property (in_valid |=>
    fields_ff.jump_low == {$past(in_word[25:0]), 2'b00})
    else $error("jump target bits wrong");
  a_third_cop_l2: assert property (in_valid && mode == CID_MODE_L2 &&
    THIRD_COPROC_MASK[in_word[31:26]] |=> ctrl_ff.reserved_exc &&
    ctrl_ff.cop_dispatch == 4'h0)
    else $error("third coprocessor accepted in level 2 mode");
  a_third_cop_l3: assert property (in_valid && mode == CID_MODE_L3 &&
    in_word[31:26] == 6'h13 |=> ctrl_ff.reserved_exc)
    else $error("third coprocessor class accepted at level 3");
  a_special_only: assert property (ctrl_ff.special |->
    fields_ff.opcode == 6'h00 && !ctrl_ff.register_immediate_class)
    else $error("function decode outside its class");
  a_float_ls: assert property (in_valid && mode == CID_MODE_L4 &&
    in_word[31:26] == 6'h31 ##1 out_valid_ff |->
    ctrl_ff.float_load_store && ctrl_ff.cop_dispatch == 4'h2)
    else $error("float load not dispatched");
  a_level_incl: assert property (in_valid && mode == CID_MODE_L4 &&
    in_word[31:26] == 6'h23 |=> !ctrl_ff.reserved_exc)
    else $error("earlier-level opcode refused");
  a_valid_idle: assert property (!out_valid_ff |->
    ctrl_ff == '0 && !wr_en_ff)
    else $error("controls active without a word");

  // split-out register and immediate fields follow the word
  a_reg_fields: assert property (in_valid |=>
    fields_ff.source_specifier == $past(in_word[25:21]) &&
    fields_ff.target_specifier == $past(in_word[20:16]) &&
    fields_ff.dest_specifier == $past(in_word[15:11]) &&
    fields_ff.imm == $past(in_word[15:0]))
    else $error("register or immediate field wrong");

  // target field picks the operation, so the class must be flagged
  a_rimm_class: assert property (in_valid &&
    in_word[31:26] == 6'h01 |=> ctrl_ff.register_immediate_class &&
    !ctrl_ff.special)
    else $error("register-immediate class not flagged");

  // an unlisted function code is refused, not guessed at
  a_func_resv: assert property (in_valid &&
    in_word[31:26] == 6'h00 && in_word[5:0] == 6'h05
    |=> ctrl_ff.special && ctrl_ff.reserved_exc)
    else $error("unlisted function code accepted");

  sequence s_cmov_in;
    in_valid && mode == CID_MODE_L4 && in_word[31:26] == 6'h00 &&
    in_word[5:0] == CMOV_FUNC;
  endsequence

  sequence s_cmov_out;
    ctrl_ff.cond_move_float_flag && ctrl_ff.cop_dispatch == 4'h2;
  endsequence

  // float-flag move leaves as float work, never as a plain op
  a_cmov_float: assert property (s_cmov_in |=> s_cmov_out)
    else $error("float-flag move not sent to float unit");

  // level-2-only mode must refuse what only level 4 adds
  a_l2_mode: assert property (in_valid && mode == CID_MODE_L2 &&
    in_word[31:26] == 6'h00 && in_word[5:0] == CMOV_FUNC
    |=> ctrl_ff.reserved_exc)
    else $error("level 4 function accepted in level 2 mode");

  // system control class passes on with no decode of its own
  a_sysctl_pass: assert property (in_valid &&
    in_word[31:26] == 6'h10 |=> ctrl_ff.cop_dispatch == 4'h1 &&
    !ctrl_ff.reserved_exc)
    else $error("system control class not passed on");

  // second coprocessor reaches its unit only when it is fitted
  a_second_cp: assert property (in_valid &&
    in_word[31:26] == 6'h12 |=> ctrl_ff.cop_dispatch ==
    (CP2_PRESENT ? 4'h4 : 4'h0))
    else $error("second coprocessor class misrouted");

endmodule

// File: sim/cid_fetch_model.sv
`timescale 1ns/1ps
// fetch stage stand-in: one word per cycle while req is high
module cid_fetch_model (
  input  wire logic        core_clk,      // core clock
  input  wire logic        req,           // present a word now
  input  wire logic [31:0] req_word,      // word to present
  input  wire logic [1:0]  req_addr_low,  // low fetch address bits
  input  wire logic [63:0] req_src,       // source register value
  output logic             in_valid,      // word present
  output logic [31:0]      in_word,       // instruction word
  output logic [1:0]       in_addr_low,   // fetch address bits 1..0
  output logic [63:0]      source_value   // source register value
);
  logic [31:0] last_word;                 // last word presented
  logic [1:0]  last_addr;                 // last address bits
  logic [63:0] last_src;                  // last source value

  // remember what was shown so idle lines can show its inverse
  always_ff @(posedge core_clk)
  begin
    if (req)
    begin
      last_word <= req_word;
      last_addr <= req_addr_low;
      last_src  <= req_src;
    end
  end

  // idle lines carry junk, never a stale copy the decoder might reuse
  always_comb
  begin
    in_valid     = req;
    in_word      = req ? req_word : ~last_word;
    in_addr_low  = req ? req_addr_low : ~last_addr;
    source_value = req ? req_src : ~last_src;
  end
endmodule

// File: sim/cpu_instruction_decode_tb.sv
`timescale 1ns/1ps
module cpu_instruction_decode_tb;
  import cid_pkg::*;
  logic        core_clk, resetn, req;    // clock, reset, request
  logic [31:0] req_word, in_word;        // word asked for and shown
  logic [1:0]  req_addr_low, in_addr_low; // low address bits
  logic [63:0] req_src, source_value;    // source register value
  logic        in_valid;                 // word present
  cid_mode_e   mode;                     // architecture mode
  cid_fields_s fields_ff;                // split fields
  cid_ctrl_s   ctrl_ff;                  // class and dispatch
  logic        out_valid_ff, wr_en_ff;   // result valid, write
  logic [4:0]  wr_idx_ff;                // write index
  logic [63:0] wr_data_ff;               // write data
  int          n_mismatch, n_compared;   // bookkeeping

  cid_fetch_model u_cid_fetch_model (.core_clk(core_clk), .req(req),
    .req_word(req_word), .req_addr_low(req_addr_low), .req_src(req_src),
    .in_valid(in_valid), .in_word(in_word), .in_addr_low(in_addr_low),
    .source_value(source_value));
  cid_decode u_cid_decode (.core_clk(core_clk), .resetn(resetn),
    .in_valid(in_valid), .in_word(in_word), .in_addr_low(in_addr_low),
    .mode(mode), .source_value(source_value), .fields_ff(fields_ff),
    .ctrl_ff(ctrl_ff), .out_valid_ff(out_valid_ff), .wr_en_ff(wr_en_ff),
    .wr_idx_ff(wr_idx_ff), .wr_data_ff(wr_data_ff));

  // 100 MHz core clock
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // one comparison, counted either way
  task automatic chk(input logic [63:0] got, exp, input string what);
    n_compared++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: %s got %0h exp %0h", $time, what,
               got, exp);
    end
  endtask

  // one word in for one cycle, result looked at in the cycle after
  task automatic issue(input logic [31:0] w, input logic [1:0] a,
                       input logic [63:0] s, input cid_mode_e m);
    @(posedge core_clk);
    #1;
    mode = m;
    req = 1'b1;
    req_word = w;
    req_addr_low = a;
    req_src = s;
    @(posedge core_clk);
    #1;
    req = 1'b0;
    chk(64'(out_valid_ff), 64'h1, "out valid");
  endtask

  // plain word, check the reserved flag and out valid
  task automatic rsv(input logic [31:0] w, input cid_mode_e m,
                     input logic e);
    issue(w, 2'h0, 64'h0, m);
    chk(64'(ctrl_ff.reserved_exc), 64'(e), "reserved");
  endtask

  // sign bit of the constant set: must not spread upward
  task automatic t_xor;
    logic [63:0] s;
    s = 64'hFFFF_FFFF_FFFF_0F0F;
    issue({6'h0E, 5'd1, 5'd2, 16'h8001}, 2'h0, s, CID_MODE_L4);
    chk(64'(wr_en_ff), 64'h1, "xor write");
    chk(64'(wr_idx_ff), 64'h2, "xor target");
    chk(wr_data_ff, s ^ {48'h0, 16'h8001}, "xor data");
    chk(64'(ctrl_ff), 64'h0, "xor ctrl");
    chk(64'(fields_ff.imm), 64'h8001, "imm");
    $display("test xor done");
  endtask

  // register-type split and jump index
  task automatic t_fields;
    issue({6'h00, 5'd3, 5'd4, 5'd5, 5'd17, 6'h00}, 2'h0, 64'h0,
          CID_MODE_L4);
    chk(64'(fields_ff.opcode), 64'h0, "opcode");
    chk(64'(fields_ff.source_specifier), 64'h3, "src");
    chk(64'(fields_ff.target_specifier), 64'h4, "tgt");
    chk(64'(fields_ff.dest_specifier), 64'h5, "dst");
    chk(64'(fields_ff.shift_amount), 64'h11, "shamt");
    chk(64'(ctrl_ff.special), 64'h1, "special");
    issue({6'h02, 26'h2AB_CDEF}, 2'h0, 64'h0, CID_MODE_L4);
    chk(64'(fields_ff.jump_low), 64'({26'h2AB_CDEF, 2'b00}), "jump");
    chk(64'(ctrl_ff.special), 64'h0, "not special");
    $display("test fields done");
  endtask

  // target field picks the operation under the register-immediate class
  task automatic t_imm_class;
    logic [4:0] t[4] = '{5'h00, 5'h0A, 5'h04, 5'h11};
    logic       e[4] = '{1'b0, 1'b0, 1'b1, 1'b0};
    for (int i = 0; i < 4; i++)
    begin
      rsv({6'h01, 5'd7, t[i], 16'h0}, CID_MODE_L4, e[i]);
      chk(64'(ctrl_ff.register_immediate_class), 64'h1, "rimm");
    end
    $display("test register_immediate_class done");
  endtask

  // function field counts only under the register-function class
  task automatic t_func;
    rsv({26'h0, 6'h01}, CID_MODE_L4, 1'b0);
    chk(64'(ctrl_ff.cond_move_float_flag), 64'h1, "movf");
    chk(64'(ctrl_ff.cop_dispatch), 64'h2, "movf unit");
    chk(64'(fields_ff.func), 64'h1, "func");
    rsv({26'h0, 6'h01}, CID_MODE_L2, 1'b1);
    rsv({26'h0, 6'h05}, CID_MODE_L4, 1'b1);
    rsv({6'h08, 20'h0, 6'h01}, CID_MODE_L4, 1'b0);
    chk(64'(ctrl_ff.cond_move_float_flag), 64'h0, "no movf");
    $display("test func done");
  endtask

  // coprocessor classes go out on the dispatch lines
  task automatic t_cop;
    logic [5:0] op[9] = '{6'h10, 6'h11, 6'h12, 6'h31, 6'h3D, 6'h32,
                          6'h13, 6'h13, 6'h33};
    cid_mode_e  m[9] = '{CID_MODE_L4, CID_MODE_L4, CID_MODE_L4,
                         CID_MODE_L2, CID_MODE_L4, CID_MODE_L4,
                         CID_MODE_L4, CID_MODE_L3, CID_MODE_L2};
    logic [3:0] d[9] = '{4'h1, 4'h2, 4'h4, 4'h2, 4'h2, 4'h4, 4'h2,
                         4'h0, 4'h0};
    logic       f[9] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0,
                         1'b0, 1'b0};
    for (int i = 0; i < 9; i++)
    begin
      rsv({op[i], 26'h0}, m[i], i > 6);
      if (i < 7)
      begin
        chk(64'(ctrl_ff.cop_dispatch), 64'(d[i]), "dispatch");
        chk(64'(ctrl_ff.float_load_store), 64'(f[i]), "fls");
        chk(64'(ctrl_ff.float_indexed_class), 64'(i == 6), "fx");
      end
    end
    $display("test cop done");
  endtask

  // an older opcode stays legal and three others stay refused in every mode
  task automatic t_mode;
    cid_mode_e ml[3] = '{CID_MODE_L2, CID_MODE_L3, CID_MODE_L4};
    for (int i = 0; i < 3; i++)
    begin
      rsv({6'h14, 26'h0}, ml[i], 1'b0);
      rsv({6'h18, 26'h0}, ml[i], 1'b1);
      rsv({6'h2F, 26'h0}, ml[i], 1'b1);
      rsv({6'h3B, 26'h0}, ml[i], 1'b1);
    end
    rsv({6'h13, 26'h0}, CID_MODE_L2, 1'b1);
    $display("test mode done");
  endtask

  // misaligned fetch blocks the write
  task automatic t_align;
    for (int i = 1; i < 4; i++)
    begin
      issue({6'h0E, 5'd1, 5'd2, 16'h1}, 2'(i), 64'h5, CID_MODE_L4);
      chk(64'(ctrl_ff.align_exc), 64'h1, "align");
      chk(64'(wr_en_ff), 64'h0, "no write");
    end
    $display("test align done");
  endtask

  // two words back to back, then idle
  task automatic t_b2b;
    @(posedge core_clk);
    #1;
    req = 1'b1;
    req_addr_low = 2'h0;
    req_src = 64'hA;
    req_word = {6'h0E, 5'd1, 5'd3, 16'h3};
    @(posedge core_clk);
    #1;
    req_word = {6'h0E, 5'd1, 5'd4, 16'hF};
    chk(wr_data_ff, 64'h9, "first");
    @(posedge core_clk);
    #1;
    req = 1'b0;
    chk(64'(wr_idx_ff), 64'h4, "second");
    chk(wr_data_ff, 64'h5, "second data");
    @(posedge core_clk);
    #1;
    chk(64'({out_valid_ff, wr_en_ff, ctrl_ff}), 64'h0, "idle");
    $display("test b2b done");
  endtask

  // reset in mid-run clears every output, then decoding resumes
  task automatic t_reset;
    issue({6'h0E, 5'd1, 5'd6, 16'h00F0}, 2'h0, 64'h1, CID_MODE_L4);
    chk(64'(wr_en_ff), 64'h1, "before reset");
    resetn = 1'b0;
    #1;
    chk(64'({out_valid_ff, wr_en_ff, ctrl_ff}), 64'h0, "in reset");
    chk(wr_data_ff, 64'h0, "data in reset");
    repeat (2) @(posedge core_clk);
    #1;
    resetn = 1'b1;
    issue({6'h0E, 5'd1, 5'd6, 16'h00F0}, 2'h0, 64'h1, CID_MODE_L4);
    chk(wr_data_ff, 64'hF1, "after reset");
    $display("test reset done");
  endtask

  // verdict and end of run
  task automatic results;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // main sequence
  initial
  begin
    resetn = 1'b0;
    req = 1'b0;
    req_word = 32'h0;
    req_addr_low = 2'h0;
    req_src = 64'h0;
    mode = CID_MODE_L4;
    repeat (8) @(posedge core_clk);
    #1;
    resetn = 1'b1;
    t_xor();
    t_fields();
    t_imm_class();
    t_func();
    t_cop();
    t_mode();
    t_align();
    t_b2b();
    t_reset();
    results();
  end

  // about 100 cycles needed; give far more before calling it a hang
  initial
  begin
    #20000;
    n_mismatch++;
    results();
  end
endmodule
